// ---- wr_port_pkg.sv ----
// Constants and types shared by the write port ends
// Notes on behaviour
// - Write data up to 36 bits, both phases
// - Low port select at true edge starts write
// - High port select ignores data, no write
// - x8: nibble selects cover bits 3:0, 7:4
// - Nibble select sampled with its word
// - x36: four byte selects cover nine bits each
// - x9: lane zero 8:0; x18: lane zero 8:0, lane one 17:9
// - Byte select sampled with its word
// - Address shared, write address on complement edge
package wr_port_pkg;
  // ****************************************
  // Organisation and widths
  // ****************************************
  localparam int DATA_W = 36;     // Widest organisation
  localparam int ADDR_W = 4;      // Modelled array depth index
  localparam int LANES = 4;       // Lane selects at x36
  localparam int NIBBLE_W = 4;    // Lane width for x8
  localparam int BYTE_W = 9;      // Lane width for x9/x18/x36
  localparam int FIFO_DEPTH = 4;  // Request buffer depth
  // ****************************************
  // Link clock divider
  // ****************************************
  localparam int LINK_PERIOD_NS = 160;  // Link clock period
  localparam int SYS_PERIOD_NS = 10;    // System clock period
  localparam int HALF_CYC = LINK_PERIOD_NS / SYS_PERIOD_NS / 2;  // Half period, cycles
  localparam logic [ADDR_W-1:0] ADDR_RST = 4'h0;  // Address reset value
  // One burst request: address, two words, two lane masks
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] word0;
    logic [DATA_W-1:0] word1;
    logic [LANES-1:0] lane0_n;
    logic [LANES-1:0] lane1_n;
  } burst_t;
endpackage : wr_port_pkg

// ---- wr_port_if.sv ----
// Link signals between controller and memory write port
`timescale 1ns/1ns
interface wr_port_if;
  import wr_port_pkg::*;
  logic clk_true;                      // True-phase clock
  logic clk_comp;                      // Complement-phase clock
  logic write_port_select_n;           // Active low write select
  logic read_port_select_n;            // Read select, held high here
  logic [ADDR_W-1:0] addr;             // Shared address bus
  logic [DATA_W-1:0] data;             // Write data
  logic [LANES-1:0] byte_lane_enable_n;  // Lane selects (nibble at x8)
  modport ctrl (output clk_true, clk_comp, write_port_select_n, read_port_select_n,
    addr, data, byte_lane_enable_n);
  modport mem (input clk_true, clk_comp, write_port_select_n, read_port_select_n,
    addr, data, byte_lane_enable_n);
endinterface : wr_port_if

// ---- burst_fifo.sv ----
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ns
module burst_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];  // Storage
  logic [PW-1:0] wr_ptr_r;          // Write index
  logic [PW-1:0] rd_ptr_r;          // Read index
  logic [PW:0] count_r;             // Fill level
  logic [PW:0] count_nxt;           // Fill level after this edge
  logic in_ready_r;                 // Registered room flag
  logic push;
  logic pop;
  assign count_nxt = count_r + (PW+1)'(push) - (PW+1)'(pop);
  // Room flag from a flop, so the request side sees no combinational path
  assign in_ready_o = in_ready_r;
  assign out_valid_o = (count_r != '0);
  assign out_data_o = mem_r[rd_ptr_r];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  // ****************************************
  // Storage write
  // ****************************************
  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end
  // Pointers and level
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
      in_ready_r <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == PW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == PW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
      end
      count_r <= count_nxt;
      in_ready_r <= (count_nxt != (PW+1)'(DEPTH));
    end
  end
endmodule : burst_fifo

// ---- wr_ctrl_end.sv ----
// Controller end: buffers bursts and drives them onto the link
`timescale 1ns/1ns
module wr_ctrl_end
  import wr_port_pkg::*;
#(
  parameter int ORG_W = DATA_W  // Organisation width: 8, 9, 18 or 36
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic [ADDR_W-1:0] req_addr_i,
  input wire logic [DATA_W-1:0] req_word0_i,
  input wire logic [DATA_W-1:0] req_word1_i,
  input wire logic [LANES-1:0] req_lane0_n_i,
  input wire logic [LANES-1:0] req_lane1_n_i,
  output logic busy_o,
  wr_port_if.ctrl link
);
  typedef enum logic [1:0] {IDLE, TRUE_PH, COMP_PH} ctl_state_t;
  ctl_state_t state_r;
  logic [$clog2(HALF_CYC+1)-1:0] div_r;  // Half period counter
  logic phase_r;                         // Half period kind: 0 true, 1 complement
  logic half_end;
  burst_t in_b;
  burst_t head;
  logic head_valid;
  logic head_pop;
  logic fifo_ready;
  logic [DATA_W-1:0] org_mask;
  assign in_b = '{req_addr_i, req_word0_i, req_word1_i, req_lane0_n_i, req_lane1_n_i};
  assign req_ready_o = fifo_ready;
  assign half_end = (div_r == ($bits(div_r))'(HALF_CYC - 1));
  assign head_pop = half_end && (state_r == COMP_PH);
  // Bits above the organisation width are driven low
  assign org_mask = {DATA_W{1'b1}} >> (DATA_W - ORG_W);
  burst_fifo #(.WIDTH($bits(burst_t)), .DEPTH(FIFO_DEPTH)) burst_fifo_i (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .in_valid_i(req_valid_i),
    .in_ready_o(fifo_ready),
    .in_data_i(in_b),
    .out_valid_o(head_valid),
    .out_ready_i(head_pop),
    .out_data_o(head)
  );
  // ****************************************
  // Clock divider and phase sequencing
  // ****************************************
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div_r <= '0;
      phase_r <= 1'b0;
      state_r <= IDLE;
    end else begin
      div_r <= half_end ? '0 : div_r + 1'b1;
      if (half_end) begin
        // Halves alternate true, complement; a burst may start only on a true half
        phase_r <= !phase_r;
        unique case (state_r)
          IDLE: state_r <= (phase_r && head_valid) ? TRUE_PH : IDLE;
          TRUE_PH: state_r <= COMP_PH;
          COMP_PH: state_r <= IDLE;
        endcase
      end
    end
  end
  // Link pins, each half period sets up before its rising edge
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      link.clk_true <= 1'b0;
      link.clk_comp <= 1'b1;
      link.write_port_select_n <= 1'b1;
      link.read_port_select_n <= 1'b1;
      link.addr <= ADDR_RST;
      link.data <= '0;
      link.byte_lane_enable_n <= '1;
      busy_o <= 1'b0;
    end else begin
      busy_o <= head_valid || (state_r != IDLE);
      if (div_r == ($bits(div_r))'(HALF_CYC / 2)) begin
        // Free-running pair: true rises mid true half, complement mid other half
        link.clk_true <= !phase_r;
        link.clk_comp <= phase_r;
      end
      if (half_end) begin
        unique case (state_r)
          IDLE: begin
            // Pins change only when a burst starts; idle edges see a deselected port
            if (phase_r && head_valid) begin
              link.write_port_select_n <= 1'b0;
              link.data <= head.word0 & org_mask;
              link.byte_lane_enable_n <= head.lane0_n;
            end
          end
          TRUE_PH: begin
            link.write_port_select_n <= 1'b1;
            link.addr <= head.addr;
            link.data <= head.word1 & org_mask;
            link.byte_lane_enable_n <= head.lane1_n;
          end
          COMP_PH: begin
            link.byte_lane_enable_n <= '1;
          end
        endcase
      end
    end
  end
endmodule : wr_ctrl_end

// ---- wr_mem_end.sv ----
// Memory end: samples link clocks, captures bursts, masks lanes
`timescale 1ns/1ns
module wr_mem_end
  import wr_port_pkg::*;
#(
  parameter int ORG_W = DATA_W  // Organisation width: 8, 9, 18 or 36
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  wr_port_if.mem link,
  input wire logic [ADDR_W-1:0] rd_addr_i,
  output logic [DATA_W-1:0] rd_word0_o,
  output logic [DATA_W-1:0] rd_word1_o,
  output logic write_done_o
);
  localparam int LW = (ORG_W == 8) ? NIBBLE_W : BYTE_W;  // Lane width
  localparam int NL = (ORG_W == 8) ? 2 : (ORG_W + BYTE_W - 1) / BYTE_W;  // Lanes used
  // Two-flop synchronisers for every link pin except read select
  logic kt_s1_r, kt_s2_r, kt_s3_r;
  logic kc_s1_r, kc_s2_r, kc_s3_r;
  logic sel_s1_r, sel_s2_r;
  logic [ADDR_W-1:0] a_s1_r, a_s2_r;
  logic [DATA_W-1:0] d_s1_r, d_s2_r;
  logic [LANES-1:0] l_s1_r, l_s2_r;
  logic [DATA_W-1:0] arr0_r [2**ADDR_W];  // First word array
  logic [DATA_W-1:0] arr1_r [2**ADDR_W];  // Second word array
  logic [DATA_W-1:0] w0_r;                // Held first word
  logic [LANES-1:0] m0_r;                 // Held first mask
  logic armed_r;                          // Write started
  logic t_rise, c_rise;
  logic [DATA_W-1:0] we0, we1;           // Bit write enables
  // ****************************************
  // Input synchronisers
  // ****************************************
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      {kt_s1_r, kt_s2_r, kt_s3_r} <= 3'h0;
      {kc_s1_r, kc_s2_r, kc_s3_r} <= 3'h7;
      {sel_s1_r, sel_s2_r} <= 2'h3;
      {a_s1_r, a_s2_r} <= '0;
      {d_s1_r, d_s2_r} <= '0;
      {l_s1_r, l_s2_r} <= '1;
    end else begin
      kt_s1_r <= link.clk_true;
      kt_s2_r <= kt_s1_r;
      kt_s3_r <= kt_s2_r;
      kc_s1_r <= link.clk_comp;
      kc_s2_r <= kc_s1_r;
      kc_s3_r <= kc_s2_r;
      sel_s1_r <= link.write_port_select_n;
      sel_s2_r <= sel_s1_r;
      a_s1_r <= link.addr;
      a_s2_r <= a_s1_r;
      d_s1_r <= link.data;
      d_s2_r <= d_s1_r;
      l_s1_r <= link.byte_lane_enable_n;
      l_s2_r <= l_s1_r;
    end
  end
  assign t_rise = kt_s2_r && !kt_s3_r;
  assign c_rise = kc_s2_r && !kc_s3_r;
  // Lane masks to per-bit enables
  genvar g;
  generate
    for (g = 0; g < DATA_W; g++) begin : g_lane
      if (g / LW < NL) begin : g_on
        assign we0[g] = !m0_r[g / LW];
        assign we1[g] = !l_s2_r[g / LW];
      end else begin : g_off
        assign we0[g] = 1'b0;
        assign we1[g] = 1'b0;
      end
    end
  endgenerate
  // ****************************************
  // First word capture on true-phase edge
  // ****************************************
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      armed_r <= 1'b0;
      w0_r <= '0;
      m0_r <= '1;
    end else if (t_rise) begin
      armed_r <= !sel_s2_r;
      w0_r <= d_s2_r;
      m0_r <= l_s2_r;
    end else if (c_rise) begin
      armed_r <= 1'b0;
    end
  end
  // Array update on complement edge, masked lanes untouched
  always_ff @(posedge clk_sys_i) begin
    if (c_rise && armed_r) begin
      arr0_r[a_s2_r] <= (arr0_r[a_s2_r] & ~we0) | (w0_r & we0);
      arr1_r[a_s2_r] <= (arr1_r[a_s2_r] & ~we1) | (d_s2_r & we1);
    end
  end
  // Read-back and completion pulse
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_word0_o <= '0;
      rd_word1_o <= '0;
      write_done_o <= 1'b0;
    end else begin
      rd_word0_o <= arr0_r[rd_addr_i];
      rd_word1_o <= arr1_r[rd_addr_i];
      write_done_o <= c_rise && armed_r;
    end
  end
endmodule : wr_mem_end

// ---- wr_port_monitor.sv ----
// Link protocol checker for the write port
`timescale 1ns/1ns
module wr_port_monitor
  import wr_port_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic clk_true,
  input wire logic clk_comp,
  input wire logic write_port_select_n,
  input wire logic read_port_select_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] data,
  input wire logic [LANES-1:0] byte_lane_enable_n
);
  // ****************************************
  // Link timing properties
  // ****************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  // True edge follows a select within a half period
  sequence s_true_edge; ##[1:8] $rose(clk_true); endsequence
  // Complement edge follows the true edge
  sequence s_comp_edge; ##[4:12] $rose(clk_comp); endsequence
  property p_rd_idle; read_port_select_n; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read select driven low");
  property p_sel_arm; $fell(write_port_select_n) |-> !write_port_select_n throughout s_true_edge;
  endproperty
  a_sel_arm: assert property (p_sel_arm) else $error("select not held to true edge");
  property p_true_data; $rose(clk_true) |-> $stable(data) && $stable(byte_lane_enable_n);
  endproperty
  a_true_data: assert property (p_true_data) else $error("word0 moved at true edge");
  property p_comp_data; $rose(clk_comp) |-> $stable(data) && $stable(addr)
    && $stable(byte_lane_enable_n); endproperty
  a_comp_data: assert property (p_comp_data) else $error("word1 moved at comp edge");
  property p_burst; ($rose(clk_true) && !write_port_select_n) |-> s_comp_edge; endproperty
  a_burst: assert property (p_burst) else $error("burst lacks second edge");
  property p_no_clash; !($rose(clk_true) && $rose(clk_comp)); endproperty
  a_no_clash: assert property (p_no_clash) else $error("both phases rose together");
  property p_true_hi; $rose(clk_true) |=> clk_true [*3]; endproperty
  a_true_hi: assert property (p_true_hi) else $error("true phase too short");
  property p_comp_hi; $rose(clk_comp) |=> clk_comp [*3]; endproperty
  a_comp_hi: assert property (p_comp_hi) else $error("comp phase too short");
endmodule : wr_port_monitor

// ---- ddr_sram_write_port_masking_bench.sv ----
// Self-checking bench joining controller and memory ends
`timescale 1ns/1ns
`define CHK(n, e, g) begin cmp_count++; if ((e) !== (g)) begin err_count++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module ddr_sram_write_port_masking_bench;
  import wr_port_pkg::*;
  // ****************************************
  // Signals and reference array
  // ****************************************
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic req_valid_i = 1'b0;
  logic req_ready_o, busy_o, write_done_o;
  logic [ADDR_W-1:0] req_addr_i = '0;
  logic [ADDR_W-1:0] rd_addr_i = '0;
  logic [DATA_W-1:0] req_word0_i = '0;
  logic [DATA_W-1:0] req_word1_i = '0;
  logic [LANES-1:0] req_lane0_n_i = 4'hf;
  logic [LANES-1:0] req_lane1_n_i = 4'hf;
  logic [DATA_W-1:0] rd_word0_o, rd_word1_o;
  logic [DATA_W-1:0] exp0 [16];  // Expected word0 per address
  logic [DATA_W-1:0] exp1 [16];  // Expected word1 per address
  int err_count = 0;
  int cmp_count = 0;
  logic full_seen = 1'b0;  // Set when the queue refused
  int done_count = 0;      // Commit pulses seen so far
  int done_base = 0;       // Commit pulses already waited for
  wr_port_if link_if ();
  wr_ctrl_end #(.ORG_W(36)) wr_ctrl_end_i (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_addr_i(req_addr_i),
    .req_word0_i(req_word0_i), .req_word1_i(req_word1_i), .req_lane0_n_i(req_lane0_n_i),
    .req_lane1_n_i(req_lane1_n_i), .busy_o(busy_o), .link(link_if.ctrl));
  wr_mem_end #(.ORG_W(36)) wr_mem_end_i (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .link(link_if.mem), .rd_addr_i(rd_addr_i), .rd_word0_o(rd_word0_o),
    .rd_word1_o(rd_word1_o), .write_done_o(write_done_o));
  wr_port_monitor wr_port_monitor_i (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .clk_true(link_if.clk_true), .clk_comp(link_if.clk_comp),
    .write_port_select_n(link_if.write_port_select_n),
    .read_port_select_n(link_if.read_port_select_n), .addr(link_if.addr),
    .data(link_if.data), .byte_lane_enable_n(link_if.byte_lane_enable_n));
  // ****************************************
  // Clock and shared tasks
  // ****************************************
  initial begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  // Count commit pulses all the time, so none is lost while a send waits
  always @(negedge clk_sys_i) begin
    if (write_done_o === 1'b1) done_count++;
  end
  // Verdict and end of run
  task automatic tally_and_finish;
    if (err_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  // Lane merge: only enabled 9-bit lanes change
  function automatic logic [35:0] merge(logic [35:0] o, logic [35:0] w, logic [3:0] l);
    for (int i = 0; i < 4; i++) if (!l[i]) o[i*9 +: 9] = w[i*9 +: 9];
    return o;
  endfunction : merge
  // Queue one burst, hold until taken
  task automatic send(input logic [3:0] a, logic [35:0] w0, w1, logic [3:0] l0, l1);
    int n;
    @(posedge clk_sys_i);
    req_valid_i <= 1'b1;
    req_addr_i <= a;
    req_word0_i <= w0;
    req_word1_i <= w1;
    req_lane0_n_i <= l0;
    req_lane1_n_i <= l1;
    for (n = 0; n < 400; n++) begin
      @(negedge clk_sys_i);
      if (req_ready_o === 1'b1) break;
      full_seen = 1'b1;
      @(posedge clk_sys_i);
    end
    if (n == 400) begin err_count++; tally_and_finish(); end
    @(posedge clk_sys_i);
    req_valid_i <= 1'b0;
    exp0[a] = merge(exp0[a], w0, l0);
    exp1[a] = merge(exp1[a], w1, l1);
  endtask : send
  // Count commit pulses under a bound
  task automatic wait_done(input int k);
    int n;
    for (n = 0; n < 3000; n++) begin
      @(posedge clk_sys_i);
      if (done_count >= done_base + k) break;
    end
    if (n == 3000) begin err_count++; tally_and_finish(); end
    done_base += k;
  endtask : wait_done
  // Read back one address and compare
  task automatic peek(input logic [3:0] a);
    @(posedge clk_sys_i);
    rd_addr_i <= a;
    @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    `CHK("word0", exp0[a], rd_word0_o)
    `CHK("word1", exp1[a], rd_word1_o)
  endtask : peek
  // ****************************************
  // Scenarios
  // ****************************************
  // Full bursts to two addresses
  task automatic t_full;
    send(4'h3, 36'h123456789, 36'hfedcba987, 4'h0, 4'h0);
    send(4'hc, 36'h0a5a5a5a5, 36'h35a5a5a5a, 4'h0, 4'h0);
    wait_done(2);
    peek(4'h3);
    peek(4'hc);
  endtask : t_full
  // One lane at a time, mirrored lanes per word
  task automatic t_lanes;
    for (int k = 0; k < 4; k++) begin
      send(4'h3, {4{9'h1c3}} ^ k, {4{9'h0e7}} + k, ~(4'h1 << k), ~(4'h8 >> k));
      wait_done(1);
      peek(4'h3);
    end
  endtask : t_lanes
  // All lanes masked leaves contents alone
  task automatic t_masked;
    send(4'hc, 36'hfffffffff, 36'h000000000, 4'hf, 4'hf);
    wait_done(1);
    peek(4'hc);
  endtask : t_masked
  // Fill queue past depth, then drain in order
  task automatic t_fill;
    for (int k = 0; k < 6; k++) send(k[3:0] + 4'h4, 36'h111111111 * k, ~(36'h1 << k), 4'h0, 4'h0);
    `CHK("refused", 1'b1, full_seen)
    wait_done(6);
    for (int k = 0; k < 6; k++) peek(k[3:0] + 4'h4);
    repeat (100) @(posedge clk_sys_i);
    `CHK("busy", 1'b0, busy_o)
    `CHK("commits", done_base, done_count)
    peek(4'h3);
  endtask : t_fill
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (19) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    `CHK("idle_sel", 1'b1, link_if.write_port_select_n)
    `CHK("idle_lanes", 4'hf, link_if.byte_lane_enable_n)
    @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    t_full();
    t_lanes();
    t_masked();
    t_fill();
    tally_and_finish();
  end
endmodule : ddr_sram_write_port_masking_bench
